// ===== include/cache_err_pkg.sv
// Constants, types and rules of the cache error check block
// What this block does
// RL1: Parity builds keep one parity bit per data byte, one over tag plus valid.
// RL2: Instruction cache ECC: eight check bits per 64-bit word, seven over tag.
// RL3: Data cache ECC: seven check bits per 32-bit word, seven over tag.
// RL4: Data cache dirty RAM ECC: four bits over dirty and two outer attributes.
// RL5: Parity builds: mode field bits 5:3; b100 turns checking off; b011, b111 reserved.
// RL6: Parity mode b000: aborts, forced write-through and hardware recovery.
// RL7: Parity mode b101: no aborts, forced write-through, hardware recovery kept.
// RL8: ECC builds use the same field; b100 turns checking off; b011, b111 reserved.
// RL9: ECC b000 aborts with recovery; b010 aborts, forces write-through, recovers.
// RL10: ECC b101 no aborts with recovery; b110 no aborts, write-through, recovery.
// RL11: Parity active forces write-through; parity error invalidates line for refetch.
// RL12: Enabled aborts still correct the error; disabled aborts leave only events.
// RL13: Errors from coherency port maintenance never cause an abort.
// RL14: ECC error evicts line: clean invalidated, dirty written out corrected, reloaded.
// RL15: Double error in tag or dirty RAM of dirty line: no write, always abort.
// RL16: Double error in data RAM of dirty line: write with strobes low, abort.
// RL17: ECC forced write-through makes lines never dirty; recovery by invalidation.
// RL18: Instruction read errors are correctable; prefetch abort records address, way.
// RL19: Data read error aborts synchronously if enabled or uncorrectable; records address.
// RL20: Data write error aborts asynchronously; address undefined; way and index kept.
// RL21: Write error in write-through region still writes the store to memory.
// RL22: Correctable eviction error corrected inline; abort per mode; every error emits event.
package cache_err_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFFSET        = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET      = 8'h04;
    localparam logic [7:0]  FAULT_ADDR_OFFSET  = 8'h08;
    localparam logic [7:0]  FAULT_CAUSE_OFFSET = 8'h0C;
    localparam logic [7:0]  CORR_COUNT_OFFSET  = 8'h10;
    localparam logic [7:0]  FATAL_COUNT_OFFSET = 8'h14;
    localparam int          MODE_LSB           = 3;
    localparam int          MODE_MSB           = 5;
    localparam logic [2:0]  MODE_RESET         = 3'h0;
    localparam int          CAUSE_VALID_BIT    = 31;

    // ------------------------------------------------------------------
    // Mode codes of the behaviour field
    // ------------------------------------------------------------------
    localparam logic [2:0]  MODE_ABORT         = 3'h0;
    localparam logic [2:0]  MODE_ABORT_WT      = 3'h2;
    localparam logic [2:0]  MODE_OFF           = 3'h4;
    localparam logic [2:0]  MODE_QUIET         = 3'h5;
    localparam logic [2:0]  MODE_QUIET_WT      = 3'h6;
    localparam logic [2:0]  MODE_RSVD_A        = 3'h3;
    localparam logic [2:0]  MODE_RSVD_B        = 3'h7;

    // ------------------------------------------------------------------
    // Protected field widths and check code widths
    // ------------------------------------------------------------------
    localparam int          IC_WORD_BITS       = 64;
    localparam int          IC_CODE_BITS       = 8;
    localparam int          DC_WORD_BITS       = 32;
    localparam int          DC_CODE_BITS       = 7;
    localparam int          TAG_BITS           = 23;
    localparam int          TAG_CODE_BITS      = 7;
    localparam int          DIRTY_BITS         = 3;
    localparam int          DIRTY_CODE_BITS    = 4;

    // Fault cause codes
    localparam logic [3:0]  CAUSE_PREFETCH_RD  = 4'h1;
    localparam logic [3:0]  CAUSE_SYNC_RD      = 4'h2;
    localparam logic [3:0]  CAUSE_ASYNC_WR     = 4'h3;
    localparam logic [3:0]  CAUSE_ASYNC_EVICT  = 4'h4;
    localparam logic [3:0]  CAUSE_COHERENCY    = 4'h5;

    typedef enum logic [4:0] {
        SRC_IFETCH = 5'b00001,
        SRC_DREAD  = 5'b00010,
        SRC_DWRITE = 5'b00100,
        SRC_EVICT  = 5'b01000,
        SRC_ACP    = 5'b10000
    } source_t;

    typedef enum logic [2:0] {
        ARR_TAG   = 3'b001,
        ARR_DIRTY = 3'b010,
        ARR_DATA  = 3'b100
    } array_t;

    typedef struct packed {
        logic        check_en;
        logic        abort_en;
        logic        force_wt;
    } mode_cfg_t;

    typedef struct packed {
        logic        valid;
        source_t     source;
        array_t      array;
        logic        icache;
        logic        line_dirty;
        logic        wt_region;
        logic        wbwa;
        logic [31:0] addr;
        logic [1:0]  way;
        logic [8:0]  index;
        logic [63:0] word;
        logic [7:0]  code;
    } check_req_t;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic        uncorrectable;
        logic        invalidate;
        logic        evict;
        logic        write_out;
        logic [7:0]  strobe;
        logic [63:0] word;
        logic [7:0]  code;
        logic        prefetch_abort;
        logic        data_abort;
        logic        async_abort;
        logic        write_through;
    } check_rsp_t;

endpackage : cache_err_pkg

// ===== rtl/cache_err_check.sv
// Cache parity and ECC checker with recovery and AHB-Lite registers
`timescale 1ns/1ns
module cache_err_check
    import cache_err_pkg::*;
#(
    parameter bit IC_ECC = 1'b1,
    parameter bit DC_ECC = 1'b1
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Check request from the cache controller
    input  check_req_t       req,
    // Check answer and recovery decision
    output check_rsp_t       rsp,
    // Forced write-through level for the cache controller
    output logic             force_write_through,
    // Error events
    output logic             event_corrected,
    output logic             event_fatal
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [63:0] low_mask(input int n);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 64; i++) begin
            m[i] = (i < n);
        end
        return m;
    endfunction : low_mask

    // Hamming bits in the low w-1 places, overall parity on top
    function automatic logic [7:0] ham_code(input logic [63:0] d, input int n, input int w);
        logic [7:0] c;
        logic [6:0] pos;
        int         j;
        c = '0;
        j = 0;
        for (int p = 1; p < 128; p++) begin
            pos = 7'(p);
            if (((pos & (pos - 7'h01)) != 7'h00) && (j < n)) begin
                for (int k = 0; k < 7; k++) begin
                    if ((k < w - 1) && pos[k]) begin
                        c[k] = c[k] ^ d[j];
                    end
                end
                j++;
            end
        end
        c = c | (8'(^((d & low_mask(n))) ^ (^c)) << (w - 1));
        return c;
    endfunction : ham_code

    function automatic logic [63:0] ham_fix(input logic [63:0] d, input int n,
                                            input logic [6:0] syn);
        logic [63:0] f;
        logic [6:0]  pos;
        int          j;
        f = d;
        j = 0;
        for (int p = 1; p < 128; p++) begin
            pos = 7'(p);
            if (((pos & (pos - 7'h01)) != 7'h00) && (j < n)) begin
                if (pos == syn) begin
                    f[j] = ~d[j];
                end
                j++;
            end
        end
        return f;
    endfunction : ham_fix

    // Even parity per data byte, or one bit over the field
    function automatic logic [7:0] par_code(input logic [63:0] d, input int n, input logic per_byte);
        logic [7:0]  c;
        logic [63:0] m;
        c = '0;
        m = d & low_mask(n);
        if (per_byte) begin
            for (int b = 0; b < 8; b++) begin
                c[b] = ^m[b*8 +: 8];
            end
        end else begin
            c[0] = ^m;
        end
        return c;
    endfunction : par_code

    // Blank table rows follow the row above; reserved codes act as the abort mode
    function automatic mode_cfg_t mode_decode(input logic [2:0] m, input logic ecc);
        mode_cfg_t cfg;
        cfg = '{check_en: 1'b1, abort_en: 1'b1, force_wt: 1'b1};
        if (!ecc) begin
            unique case (m)
                MODE_OFF:                cfg = '{1'b0, 1'b0, 1'b0};           // RL5
                MODE_QUIET, MODE_QUIET_WT: cfg = '{1'b1, 1'b0, 1'b1};         // RL7
                default:                 cfg = '{1'b1, 1'b1, 1'b1};           // RL6
            endcase
        end else begin
            unique case (m)
                MODE_OFF:                cfg = '{1'b0, 1'b0, 1'b0};           // RL8
                MODE_ABORT_WT:           cfg = '{1'b1, 1'b1, 1'b1};           // RL9
                MODE_QUIET:              cfg = '{1'b1, 1'b0, 1'b0};           // RL10
                MODE_QUIET_WT:           cfg = '{1'b1, 1'b0, 1'b1};           // RL10
                default:                 cfg = '{1'b1, 1'b1, 1'b0};           // RL9
            endcase
        end
        return cfg;
    endfunction : mode_decode

    // ------------------------------------------------------------------
    // Control state and mode
    // ------------------------------------------------------------------
    logic [2:0]  mode;
    logic [31:0] fault_address_record;
    logic [31:0] fault_cause_record;
    logic [31:0] corr_count;
    logic [31:0] fatal_count;
    mode_cfg_t   ic_cfg;
    mode_cfg_t   dc_cfg;
    mode_cfg_t   cfg;
    logic        ecc;

    assign ic_cfg = mode_decode(mode, IC_ECC);
    assign dc_cfg = mode_decode(mode, DC_ECC);
    assign ecc    = req.icache ? IC_ECC : DC_ECC;
    assign cfg    = req.icache ? ic_cfg : dc_cfg;

    // Only the data side can hold dirty lines
    assign force_write_through = dc_cfg.check_en && dc_cfg.force_wt;         // RL11 RL17

    // ------------------------------------------------------------------
    // Check of the presented field
    // ------------------------------------------------------------------
    int          n_bits;
    int          w_code;
    logic [7:0]  calc;
    logic [7:0]  cmask;
    logic [6:0]  syn;
    logic        overall;
    logic        single_err;
    logic        double_err;
    logic [63:0] fixed;

    always_comb begin
        n_bits = TAG_BITS;
        w_code = TAG_CODE_BITS;
        unique case (req.array)
            ARR_TAG: begin
                n_bits = TAG_BITS;                                           // RL1 RL2 RL3
                w_code = ecc ? TAG_CODE_BITS : 1;
            end
            ARR_DIRTY: begin
                n_bits = DIRTY_BITS;                                         // RL4
                w_code = ecc ? DIRTY_CODE_BITS : 0;
            end
            ARR_DATA: begin
                n_bits = req.icache ? IC_WORD_BITS : DC_WORD_BITS;
                w_code = ecc ? (req.icache ? IC_CODE_BITS : DC_CODE_BITS)    // RL2 RL3
                             : n_bits / 8;                                   // RL1
            end
            default: begin
                n_bits = TAG_BITS;
                w_code = 0;
            end
        endcase
    end

    always_comb begin
        cmask      = 8'(low_mask(w_code));
        syn        = '0;
        overall    = 1'b0;
        single_err = 1'b0;
        double_err = 1'b0;
        fixed      = req.word & low_mask(n_bits);
        if (ecc) begin
            calc       = ham_code(req.word, n_bits, w_code);
            syn        = 7'((calc ^ req.code) & (cmask >> 1));
            overall    = ^(req.word & low_mask(n_bits)) ^ ^(req.code & cmask);
            single_err = overall;
            double_err = !overall && (syn != 7'h00);
            if (single_err) begin
                fixed = ham_fix(fixed, n_bits, syn);
            end
        end else begin
            calc       = par_code(req.word, n_bits, req.array == ARR_DATA);
            single_err = ((calc ^ req.code) & cmask) != 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Recovery and abort decision
    // ------------------------------------------------------------------
    check_rsp_t next_rsp;
    logic       err;
    logic       uncorr;
    logic       dirty_eff;
    logic       abort_any;

    always_comb begin
        err       = req.valid && cfg.check_en && (single_err || double_err);
        // An instruction line can always be refetched
        uncorr    = err && double_err && !req.icache;                          // RL18
        dirty_eff = req.line_dirty && !cfg.force_wt && !req.icache;          // RL17
        abort_any = err && (cfg.abort_en || uncorr)                          // RL12 RL15 RL16
                    && (req.source != SRC_ACP);                              // RL13
        next_rsp                = '0;
        next_rsp.valid          = req.valid;
        next_rsp.error          = err;
        next_rsp.uncorrectable  = uncorr;
        next_rsp.word           = fixed;                                     // RL14 RL22
        next_rsp.code           = ecc ? ham_code(fixed, n_bits, w_code)
                                      : par_code(fixed, n_bits, req.array == ARR_DATA);
        next_rsp.strobe         = req.icache ? 8'hFF : 8'h0F;
        next_rsp.write_through  = req.wbwa && cfg.check_en && cfg.force_wt;  // RL11 RL17
        if (err) begin
            if (dirty_eff) begin
                next_rsp.evict     = 1'b1;                                   // RL14
                next_rsp.write_out = !(uncorr && req.array != ARR_DATA);     // RL15
            end else begin
                next_rsp.invalidate = 1'b1;                                  // RL11 RL14 RL17
            end
            if (uncorr && req.array == ARR_DATA) begin
                next_rsp.strobe = 8'h00;                                     // RL16
            end
        end else if (req.valid && req.source == SRC_EVICT) begin
            next_rsp.write_out = dirty_eff;
        end
        if (req.valid && req.source == SRC_DWRITE && (req.wt_region || next_rsp.write_through)) begin
            next_rsp.write_out = 1'b1;                                       // RL21
        end
        next_rsp.prefetch_abort = abort_any && req.source == SRC_IFETCH;      // RL18
        next_rsp.data_abort     = abort_any && req.source == SRC_DREAD;       // RL19
        next_rsp.async_abort    = abort_any
                                  && (req.source == SRC_DWRITE || req.source == SRC_EVICT); // RL20 RL22
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_corrected <= 1'b0;
            event_fatal     <= 1'b0;
        end else begin
            event_corrected <= err && !uncorr;                               // RL12 RL22
            event_fatal     <= uncorr;
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------------
    logic       ph_write;
    logic [7:0] ph_addr;
    logic       take;
    logic       cause_clear;
    logic [3:0] cause;
    logic [31:0] rd_word;

    assign take        = hsel && htrans[1] && hready;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign cause_clear = ph_write && ph_addr == FAULT_CAUSE_OFFSET;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_write <= 1'b0;
            ph_addr  <= '0;
        end else begin
            ph_write <= take && hwrite;
            ph_addr  <= take ? haddr[7:0] : ph_addr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= MODE_RESET;
        end else if (ph_write && ph_addr == CTRL_OFFSET) begin
            mode <= hwdata[MODE_MSB:MODE_LSB];                               // RL5 RL8
        end
    end

    always_comb begin
        unique case (req.source)
            SRC_IFETCH: cause = CAUSE_PREFETCH_RD;
            SRC_DREAD:  cause = CAUSE_SYNC_RD;
            SRC_DWRITE: cause = CAUSE_ASYNC_WR;
            SRC_EVICT:  cause = CAUSE_ASYNC_EVICT;
            default:    cause = CAUSE_COHERENCY;
        endcase
    end

    // Only synchronous faults load the address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_address_record <= '0;
        end else if (err && (req.source == SRC_IFETCH || req.source == SRC_DREAD)) begin
            fault_address_record <= req.addr;                                // RL18 RL19
        end
    end

    // A new fault in the clearing cycle wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_cause_record <= '0;
        end else if (err) begin
            fault_cause_record <= {1'b1, 15'h0000, req.index, req.way, uncorr, cause}; // RL20
        end else if (cause_clear) begin
            fault_cause_record[CAUSE_VALID_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            corr_count  <= '0;
            fatal_count <= '0;
        end else begin
            corr_count  <= corr_count + 32'(err && !uncorr);
            fatal_count <= fatal_count + 32'(uncorr);
        end
    end

    always_comb begin
        unique case (haddr[7:0])
            CTRL_OFFSET:        rd_word = {26'h0, mode, 3'h0};
            STATUS_OFFSET:      rd_word = {27'h0, DC_ECC, IC_ECC, dc_cfg.force_wt,
                                           dc_cfg.abort_en, dc_cfg.check_en};
            FAULT_ADDR_OFFSET:  rd_word = fault_address_record;
            FAULT_CAUSE_OFFSET: rd_word = fault_cause_record;
            CORR_COUNT_OFFSET:  rd_word = corr_count;
            FATAL_COUNT_OFFSET: rd_word = fatal_count;
            default:            rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (take && !hwrite) begin
            hrdata <= rd_word;
        end
    end

endmodule : cache_err_check

// ===== verification/cache_ctrl_model.sv
// Cache controller model: sends check requests
`timescale 1ns/1ns
module cache_ctrl_model
    import cache_err_pkg::*;
(
    // Clock
    input  wire logic       hclk,
    // Request out, answer in
    output check_req_t      req,
    input  wire check_rsp_t rsp,
    input  wire logic       event_corrected,
    input  wire logic       event_fatal
);
    initial req = '0;

    task automatic send(input check_req_t r, output check_rsp_t o, output logic [1:0] ev);
        check_req_t idle;
        idle = ~r;
        idle.valid = 1'b0;
        @(posedge hclk);
        req <= r;
        @(posedge hclk);
        // Inverted idle fields expose late sampling
        req <= idle;
        #1;
        o = rsp;
        ev = {event_corrected, event_fatal};
    endtask : send
endmodule : cache_ctrl_model

// ===== verification/cache_err_check_assertions.sv
// Assertions for the cache error check block
`timescale 1ns/1ns
module cache_err_check_assertions
    import cache_err_pkg::*;
(
    // Clock and reset
    input wire logic        hclk, hresetn,
    // Check path
    input wire check_req_t  req,
    input wire check_rsp_t  rsp,
    input wire logic        force_write_through, event_corrected, event_fatal
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    answer_one_cycle_a: assert property (rsp.valid == $past(req.valid))
        else $error("late check answer");
    acp_no_abort_a: assert property (
        req.valid && req.source == SRC_ACP |=>
        !(rsp.prefetch_abort || rsp.data_abort || rsp.async_abort))
        else $error("coherency abort");
    fatal_abort_a: assert property (
        req.valid && req.source != SRC_ACP ##1 rsp.uncorrectable |->
        rsp.data_abort || rsp.async_abort) else $error("fatal without abort");
    strobe_low_a: assert property (
        req.valid && req.array == ARR_DATA ##1 rsp.uncorrectable |-> rsp.strobe == 8'h00)
        else $error("strobes high on fatal");
    tag_no_write_a: assert property (
        req.valid && req.array != ARR_DATA ##1 rsp.uncorrectable |-> !rsp.write_out)
        else $error("fatal tag written out");
    icache_corr_a: assert property (req.valid && req.icache |=> !rsp.uncorrectable)
        else $error("fatal fetch error");
    wt_no_evict_a: assert property (
        req.valid && force_write_through && !req.icache |=> !(rsp.error && rsp.evict))
        else $error("evict under write-through");
    error_event_a: assert property (
        rsp.error |-> (rsp.uncorrectable ? event_fatal : event_corrected))
        else $error("missing error event");
    wt_store_a: assert property (
        req.valid && req.source == SRC_DWRITE && req.wt_region |=> rsp.write_out)
        else $error("store not written out");
    prefetch_src_a: assert property (
        rsp.prefetch_abort |-> $past(req.valid) && $past(req.source) == SRC_IFETCH)
        else $error("stray prefetch abort");

    cover property (event_fatal);
    cover property (rsp.evict && rsp.write_out);
    cover property (rsp.prefetch_abort);
endmodule : cache_err_check_assertions

bind cache_err_check cache_err_check_assertions cache_err_check_assertions_i (
    .hclk, .hresetn, .req, .rsp, .force_write_through, .event_corrected, .event_fatal);

// ===== verification/cache_err_check_tb.sv
// Bench for the cache error check block
`timescale 1ns/1ns
module cache_err_check_tb;
    import cache_err_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fwt, ev_c, ev_f;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    check_req_t  req;
    check_rsp_t  rsp;
    int          num_errors, cmp_count, n_corr, n_fatal;
    logic [2:0]  mt [8] = '{3'h3, 3'h3, 3'h7, 3'h3, 3'h0, 3'h1, 3'h5, 3'h3};

    cache_err_check cache_err_check_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .req(req), .rsp(rsp), .force_write_through(fwt), .event_corrected(ev_c),
        .event_fatal(ev_f));
    cache_ctrl_model cache_ctrl_model_i (.hclk(hclk), .req(req), .rsp(rsp),
        .event_corrected(ev_c), .event_fatal(ev_f));

    always #5 hclk = ~hclk;

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [71:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_rdy;
        int k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin num_errors++; stop_test; end
    endtask : wait_rdy

    task automatic xfer(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
        wait_rdy;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask : xfer

    task automatic rdchk(input logic [31:0] a, exp);
        xfer(1'b0, a, 32'h0);
        check({hresp, rd}, {1'b0, exp});
    endtask : rdchk

    // Hamming code: powers of two skipped, top bit overall parity
    function automatic logic [7:0] ecc(input logic [63:0] d, input int n, w);
        logic [7:0] c; int p;
        c = '0; p = 0;
        for (int j = 0; j < n; j++) begin
            do p++; while ((p & (p - 1)) == 0);
            for (int i = 0; i < w - 1; i++) if (p[i]) c[i] ^= d[j];
        end
        c[w-1] = ^d ^ ^c;
        return c;
    endfunction : ecc

    // Flags: error,uncorr,invalidate,evict,write_out,prefetch,data,async aborts
    task automatic run(input source_t s, input array_t a, input logic ic, dy, wt,
                       input logic [63:0] flip, input logic [7:0] ef);
        check_req_t r; check_rsp_t o; logic [1:0] ev; int n, w; logic [63:0] d;
        n = (a == ARR_DATA) ? (ic ? 64 : 32) : (a == ARR_TAG ? 23 : 3);
        w = (a == ARR_DATA && ic) ? 8 : (a == ARR_DIRTY ? 4 : 7);
        d = 64'h0123_4567_89AB_CDEF & ~({64{1'b1}} << n);
        r = '0; r.valid = 1'b1; r.source = s; r.array = a; r.icache = ic; r.wbwa = 1'b1;
        r.line_dirty = dy; r.wt_region = wt; r.addr = 32'h1F40; r.way = 2'h2;
        r.index = 9'h055; r.word = d ^ flip; r.code = ecc(d, n, w);
        cache_ctrl_model_i.send(r, o, ev);
        check({o.error, o.uncorrectable, o.invalidate, o.evict, o.write_out,
               o.prefetch_abort, o.data_abort, o.async_abort}, ef);
        check(ev, {ef[7] & !ef[6], ef[6]});
        check(o.strobe, ic ? 8'hFF : (ef[6] && a == ARR_DATA ? 8'h00 : 8'h0F));
        if ($countones(flip) == 1 && ef[7]) check({o.code, o.word}, {ecc(d, n, w), d});
        n_fatal += ef[6];
        n_corr += ef[7] & !ef[6];
    endtask : run

    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
        hsize = 3'h2; hwdata = 0; num_errors = 0; cmp_count = 0; n_corr = 0; n_fatal = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        check(fwt, 1'b0);
        rdchk(CTRL_OFFSET, 32'h0);
        rdchk(STATUS_OFFSET, 32'h1B);
        xfer(1'b1, 32'h20, 32'hFFFF_FFFF);
        rdchk(32'h20, 32'h0);
        for (int m = 0; m < 8; m++) begin
            xfer(1'b1, CTRL_OFFSET, 32'(m) << 3);
            rdchk(STATUS_OFFSET, {27'h0, 2'b11, mt[m]});
            check(fwt, mt[m][2]);
        end
        xfer(1'b1, CTRL_OFFSET, 32'h0);
        run(SRC_DREAD, ARR_DATA, 0, 0, 0, 64'h20, 8'hA2);
        rdchk(FAULT_ADDR_OFFSET, 32'h1F40);
        rdchk(FAULT_CAUSE_OFFSET, 32'h8000_2AC2);
        xfer(1'b1, FAULT_CAUSE_OFFSET, 32'h0);
        rdchk(FAULT_CAUSE_OFFSET, 32'h0000_2AC2);
        run(SRC_DREAD, ARR_DATA, 0, 0, 0, 64'h3, 8'hE2);
        run(SRC_EVICT, ARR_DATA, 0, 1, 0, 64'h3, 8'hD9);
        run(SRC_EVICT, ARR_TAG, 0, 1, 0, 64'h3, 8'hD1);
        run(SRC_EVICT, ARR_DIRTY, 0, 1, 0, 64'h3, 8'hD1);
        run(SRC_EVICT, ARR_DATA, 0, 1, 0, 64'h100, 8'h99);
        run(SRC_ACP, ARR_DATA, 0, 0, 0, 64'h1, 8'hA0);
        run(SRC_ACP, ARR_TAG, 0, 0, 0, 64'h6, 8'hE0);
        run(SRC_DWRITE, ARR_DATA, 0, 0, 1, 64'h8, 8'hA9);
        rdchk(FAULT_CAUSE_OFFSET, 32'h8000_2AC3);
        run(SRC_IFETCH, ARR_DATA, 1, 0, 0, 64'h11, 8'hA4);
        run(SRC_IFETCH, ARR_TAG, 1, 0, 0, 64'h4, 8'hA4);
        run(SRC_DREAD, ARR_DATA, 0, 0, 0, 64'h0, 8'h00);
        xfer(1'b1, CTRL_OFFSET, 32'h28);
        run(SRC_IFETCH, ARR_DATA, 1, 0, 0, 64'h80, 8'hA0);
        run(SRC_DREAD, ARR_DATA, 0, 0, 0, 64'h3, 8'hE2);
        xfer(1'b1, CTRL_OFFSET, 32'h30);
        run(SRC_EVICT, ARR_DATA, 0, 1, 0, 64'h4, 8'hA0);
        xfer(1'b1, CTRL_OFFSET, 32'h10);
        run(SRC_EVICT, ARR_DATA, 0, 1, 0, 64'h4, 8'hA1);
        xfer(1'b1, CTRL_OFFSET, 32'h20);
        run(SRC_DREAD, ARR_DATA, 0, 0, 0, 64'h4, 8'h00);
        rdchk(CORR_COUNT_OFFSET, 32'(n_corr));
        rdchk(FATAL_COUNT_OFFSET, 32'(n_fatal));
        stop_test;
    end
endmodule : cache_err_check_tb
